/* File: tcco_defs.vh */
// Function
// R1 - Up to seven identical channels, each capturing the counter or timing intervals.
// R2 - Mode-select bit 1 gives capture mode, 0 gives compare mode.
// R3 - Input-select field picks first input, second input, ground or supply.
// R4 - Edge-select field picks rising, falling or both edges; one setting disables.
// R5 - A selected capture edge copies the counter into the value and sets the flag.
// R6 - The level of the selected input is readable at any time.
// R7 - Synchronize bit aligns each capture event to the next timer clock edge.
// R8 - Second capture before the first was read sets overrun; software clears it.
// R9 - Toggling the lower select bit between supply and ground captures every change.
// R10 - Software switches between the two signal inputs only while capture is off.
// R11 - Software reads a captured value after the flag and before the next capture.
// R12 - Counting to the channel value sets the flag and pulses the match signal.
// R13 - At each compare match the selected input level is latched as sampled input.
// R14 - Software stops the counter before loading a new compare value.
// R15 - Output lines change on the timer clock rising edge except in mode 0; here mode 0 is registered on the rising edge too.
// R16 - Mode 000 drives the output from the direct-level bit.
// R17 - Mode 001 sets at channel match and holds until timer reset.
// R18 - Modes 010 and 011 toggle or set at match, clear at period match.
// R19 - Mode 100 toggles at every match; mode 101 clears at match and holds.
// R20 - Modes 110 and 111 toggle or clear at match, set at period match.
// R21 - In up/down counting the unit reacts to matches in either direction.
// R22 - Software keeps one mode bit set while changing modes on the fly.
// R23 - Channel 0 match is the period match for all output units.
`ifndef TCCO_DEFS_VH
`define TCCO_DEFS_VH

// =====================================================================
// Sizes
// =====================================================================
`define TCCO_NUM_CH      7
`define TCCO_CNT_W       16
`define TCCO_SRC_W       2
`define TCCO_EDGE_W      2
`define TCCO_MODE_W      3
`define TCCO_SYNC_DEPTH  3

// =====================================================================
// Input source field codes
// =====================================================================
`define TCCO_SRC_FIRST   2'h0
`define TCCO_SRC_SECOND  2'h1
`define TCCO_SRC_GND     2'h2
`define TCCO_SRC_VCC     2'h3

// =====================================================================
// Edge select field codes
// =====================================================================
`define TCCO_EDGE_NONE   2'h0
`define TCCO_EDGE_RISE   2'h1
`define TCCO_EDGE_FALL   2'h2
`define TCCO_EDGE_BOTH   2'h3

// =====================================================================
// Waveform mode field codes
// =====================================================================
`define TCCO_WM_DIRECT   3'h0
`define TCCO_WM_SET      3'h1
`define TCCO_WM_TOG_RST  3'h2
`define TCCO_WM_SET_RST  3'h3
`define TCCO_WM_TOGGLE   3'h4
`define TCCO_WM_RESET    3'h5
`define TCCO_WM_TOG_SET  3'h6
`define TCCO_WM_RST_SET  3'h7

// =====================================================================
// Reset values
// =====================================================================
`define TCCO_RST_VALUE   16'h0000
`define TCCO_RST_BIT     1'h0

`endif

/* File: tcco_sync.v */
`include "tcco_defs.vh"

module tcco_sync #(
   parameter W = 1
) (
   input  wire         clk_sys_i,
   input  wire         rst_b_i,
   input  wire [W-1:0] async_i,
   output wire [W-1:0] level_o
);

// =====================================================================
// Three-stage synchroniser with agreement filter
// =====================================================================
   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;
   reg [W-1:0] s3_r;
   reg [W-1:0] level_r;

   // The first stage feeds only the second stage.
   always @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         s1_r    <= {W{1'b0}};
         s2_r    <= {W{1'b0}};
         s3_r    <= {W{1'b0}};
         level_r <= {W{1'b0}};
      end else begin
         s1_r    <= async_i;
         s2_r    <= s1_r;
         s3_r    <= s2_r;
         level_r <= (s2_r & ~(s2_r ^ s3_r)) | (level_r & (s2_r ^ s3_r));
      end
   end

   assign level_o = level_r;

endmodule // tcco_sync

/* File: tcco_top.v */
`include "tcco_defs.vh"

module tcco_top #(
   parameter NCH = `TCCO_NUM_CH,
   parameter CW  = `TCCO_CNT_W
) (
   input  wire                           clk_sys_i,
   input  wire                           rst_b_i,
   input  wire [CW-1:0]                  counter_i,
   input  wire                           timer_clr_i,
   input  wire [NCH-1:0]                 measure_select_i,
   input  wire [`TCCO_SRC_W*NCH-1:0]     input_source_i,
   input  wire [`TCCO_EDGE_W*NCH-1:0]    edge_select_i,
   input  wire [NCH-1:0]                 sync_enable_i,
   input  wire [NCH-1:0]                 first_input_i,
   input  wire [NCH-1:0]                 second_input_i,
   input  wire [NCH-1:0]                 value_wr_i,
   input  wire [CW*NCH-1:0]              value_wdata_i,
   input  wire [NCH-1:0]                 value_rd_i,
   input  wire [NCH-1:0]                 flag_set_i,
   input  wire [NCH-1:0]                 flag_clr_i,
   input  wire [NCH-1:0]                 overrun_clr_i,
   input  wire [`TCCO_MODE_W*NCH-1:0]    waveform_mode_i,
   input  wire [NCH-1:0]                 direct_level_i,
   output wire [CW*NCH-1:0]              channel_value_o,
   output wire [NCH-1:0]                 channel_flag_o,
   output wire [NCH-1:0]                 capture_overrun_o,
   output wire [NCH-1:0]                 input_level_o,
   output wire [NCH-1:0]                 sampled_input_o,
   output wire [NCH-1:0]                 match_pulse_o,
   output wire [NCH-1:0]                 waveform_line_o
);

// =====================================================================
// Helper functions
// =====================================================================
   // Picks the capture source level from the input source field.
   function src_level;
      input [`TCCO_SRC_W-1:0] sel;
      input                   first;
      input                   second;
      begin
         case (sel)
            `TCCO_SRC_FIRST  : src_level = first;
            `TCCO_SRC_SECOND : src_level = second;
            `TCCO_SRC_GND    : src_level = 1'b0;
            `TCCO_SRC_VCC    : src_level = 1'b1;
            default          : src_level = 1'b0;
         endcase
      end
   endfunction

   // Decides whether a level change is a capture edge.
   function edge_hit;
      input [`TCCO_EDGE_W-1:0] es;
      input                    now;
      input                    was;
      begin
         case (es)
            `TCCO_EDGE_NONE : edge_hit = 1'b0;
            `TCCO_EDGE_RISE : edge_hit = now & ~was;
            `TCCO_EDGE_FALL : edge_hit = ~now & was;
            `TCCO_EDGE_BOTH : edge_hit = now ^ was;
            default         : edge_hit = 1'b0;
         endcase
      end
   endfunction

   // Next waveform line level; the channel match wins over the period
   // match when both come in the same cycle.
   function wave_next;
      input [`TCCO_MODE_W-1:0] md;
      input                    cur;
      input                    eqn;
      input                    eq0;
      input                    direct;
      input                    clr;
      begin
         case (md)
            `TCCO_WM_DIRECT  : wave_next = direct;
            `TCCO_WM_SET     : wave_next = eqn ? 1'b1 : (clr ? 1'b0 : cur);
            `TCCO_WM_TOG_RST : wave_next = eqn ? ~cur : (eq0 ? 1'b0 : cur);
            `TCCO_WM_SET_RST : wave_next = eqn ? 1'b1 : (eq0 ? 1'b0 : cur);
            `TCCO_WM_TOGGLE  : wave_next = eqn ? ~cur : cur;
            `TCCO_WM_RESET   : wave_next = eqn ? 1'b0 : cur;
            `TCCO_WM_TOG_SET : wave_next = eqn ? ~cur : (eq0 ? 1'b1 : cur);
            `TCCO_WM_RST_SET : wave_next = eqn ? 1'b0 : (eq0 ? 1'b1 : cur);
            default          : wave_next = cur;
         endcase
      end
   endfunction

// =====================================================================
// Pin synchronisers and counter history
// =====================================================================
   wire [NCH-1:0] first_sync;
   wire [NCH-1:0] second_sync;
   wire [NCH-1:0] eq_now;
   reg  [CW-1:0]  cnt_prev_r;

   tcco_sync #(
      .W (2*NCH)
   ) u_sync (
      .clk_sys_i (clk_sys_i),
      .rst_b_i   (rst_b_i),
      .async_i   ({second_input_i, first_input_i}),
      .level_o   ({second_sync, first_sync})
   );

   // A match needs the counter to arrive at the value, not to sit on it.
   always @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         cnt_prev_r <= `TCCO_RST_VALUE;
      end else begin
         cnt_prev_r <= counter_i;
      end
   end

// =====================================================================
// Channels
// =====================================================================
   // One identical slice per channel.
   genvar n; // see R1
   generate
      for (n = 0; n < NCH; n = n + 1) begin : g_ch
         wire [`TCCO_SRC_W-1:0]  src_sel;
         wire [`TCCO_EDGE_W-1:0] edge_sel;
         wire [`TCCO_MODE_W-1:0] wmode;
         wire [CW-1:0]           wdata;
         wire                    sel_lvl;
         wire                    raw_evt;
         wire                    cap_evt;
         wire                    is_cap;
         reg  [CW-1:0]           value_r;
         reg  [CW-1:0]           value_nxt;
         reg                     prev_lvl_r;
         reg                     evt_dly_r;
         reg                     lvl_r;
         reg                     flag_r;
         reg                     flag_nxt;
         reg                     unread_r;
         reg                     unread_nxt;
         reg                     ovr_r;
         reg                     ovr_nxt;
         reg                     sampled_input_bit_r;
         reg                     match_r;
         reg                     wave_r;

         assign src_sel  = input_source_i[`TCCO_SRC_W*n +: `TCCO_SRC_W];
         assign edge_sel = edge_select_i[`TCCO_EDGE_W*n +: `TCCO_EDGE_W];
         assign wmode    = waveform_mode_i[`TCCO_MODE_W*n +: `TCCO_MODE_W];
         assign wdata    = value_wdata_i[CW*n +: CW];
         assign is_cap   = measure_select_i[n]; // see R2

         // Ground and supply bypass the synchroniser, so a software
         // toggle of the lower select bit is seen in the next cycle.
         assign sel_lvl = src_level(src_sel, first_sync[n],
                                    second_sync[n]); // see R3, R9
         assign raw_evt = is_cap
                        & edge_hit(edge_sel, sel_lvl, prev_lvl_r); // see R4
         assign cap_evt = sync_enable_i[n] ? evt_dly_r
                                            : raw_evt; // see R7

         assign eq_now[n] = ~is_cap & (counter_i == value_r)
                          & (counter_i != cnt_prev_r); // see R12, R21

         always @* begin
            value_nxt  = value_r;
            flag_nxt   = flag_r;
            unread_nxt = unread_r;
            ovr_nxt    = ovr_r;
            if (value_wr_i[n]) begin
               value_nxt = wdata;
            end
            if (value_rd_i[n]) begin
               unread_nxt = 1'b0;
            end
            if (flag_clr_i[n]) begin
               flag_nxt = 1'b0;
            end
            if (flag_set_i[n]) begin
               flag_nxt = 1'b1;
            end
            if (overrun_clr_i[n]) begin
               ovr_nxt = 1'b0;
            end
            if (cap_evt) begin
               value_nxt  = counter_i; // see R5
               flag_nxt   = 1'b1;
               unread_nxt = 1'b1;
               if (unread_r && !value_rd_i[n]) begin
                  ovr_nxt = 1'b1; // see R8
               end
            end
            if (eq_now[n]) begin
               flag_nxt = 1'b1; // see R12
            end
         end

         always @(posedge clk_sys_i) begin
            if (!rst_b_i) begin
               value_r    <= `TCCO_RST_VALUE;
               prev_lvl_r <= `TCCO_RST_BIT;
               evt_dly_r  <= `TCCO_RST_BIT;
               lvl_r      <= `TCCO_RST_BIT;
               flag_r     <= `TCCO_RST_BIT;
               unread_r   <= `TCCO_RST_BIT;
               ovr_r      <= `TCCO_RST_BIT;
               sampled_input_bit_r     <= `TCCO_RST_BIT;
               match_r    <= `TCCO_RST_BIT;
               wave_r     <= `TCCO_RST_BIT;
            end else begin
               value_r    <= value_nxt;
               prev_lvl_r <= sel_lvl;
               evt_dly_r  <= raw_evt; // see R7
               lvl_r      <= sel_lvl; // see R6
               flag_r     <= flag_nxt;
               unread_r   <= unread_nxt;
               ovr_r      <= ovr_nxt;
               match_r    <= eq_now[n]; // see R12
               if (eq_now[n]) begin
                  sampled_input_bit_r <= sel_lvl; // see R13
               end
               // Channel 0 match acts as period match everywhere.
               wave_r <= wave_next(wmode, wave_r, eq_now[n], eq_now[0],
                                   direct_level_i[n],
                                   timer_clr_i); // see R15, R16, R17
               // The mode decode above also carries these rules.
               // see R18, R19, R20, R23
            end
         end

         assign channel_value_o[CW*n +: CW] = value_r;
         assign channel_flag_o[n]           = flag_r;
         assign capture_overrun_o[n]        = ovr_r;
         assign input_level_o[n]            = lvl_r;
         assign sampled_input_o[n]          = sampled_input_bit_r;
         assign match_pulse_o[n]            = match_r;
         assign waveform_line_o[n]          = wave_r;
      end
   endgenerate

endmodule // tcco_top

/* File: tcco_top_chk.sv */
`include "tcco_defs.vh"
// =================================================
// Port checker for the capture/compare block.
module tcco_top_chk #(
   parameter NCH = `TCCO_NUM_CH,
   parameter CW  = `TCCO_CNT_W
) (
   input wire                        clk_sys_i,
   input wire                        rst_b_i,
   input wire [CW-1:0]               counter_i,
   input wire                        timer_clr_i,
   input wire [NCH-1:0]              measure_select_i,
   input wire [NCH-1:0]              overrun_clr_i,
   input wire [`TCCO_MODE_W*NCH-1:0] waveform_mode_i,
   input wire [NCH-1:0]              direct_level_i,
   input wire [CW*NCH-1:0]           channel_value_o,
   input wire [NCH-1:0]              channel_flag_o,
   input wire [NCH-1:0]              capture_overrun_o,
   input wire [NCH-1:0]              match_pulse_o,
   input wire [NCH-1:0]              waveform_line_o
);
   wire [2:0] md1 = waveform_mode_i[5:3];
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   chk_match_cmp: assert property (
      match_pulse_o[1] |-> !$past(measure_select_i[1])) else $error("m");
   chk_match_single: assert property (
      match_pulse_o[1] |=> !match_pulse_o[1]) else $error("pulse");
   chk_match_flag: assert property (
      match_pulse_o[1] |-> channel_flag_o[1]) else $error("flag");
   chk_match_value: assert property (
      match_pulse_o[1] |-> channel_value_o[2*CW-1:CW] == $past(counter_i))
      else $error("value");
   chk_ovr_hold: assert property (
      capture_overrun_o[1] && !overrun_clr_i[1] |=> capture_overrun_o[1])
      else $error("ovr lost");
   chk_ovr_flag: assert property (
      $rose(capture_overrun_o[1]) |-> channel_flag_o[1]) else $error("ovr");
   chk_direct_mode: assert property (
      md1 == 3'h0 |=> waveform_line_o[1] == $past(direct_level_i[1]))
      else $error("direct");
   chk_toggle_mode: assert property (
      match_pulse_o[1] && $past(md1) == 3'h4
      |-> waveform_line_o[1] != $past(waveform_line_o[1])) else $error("tg");
   chk_set_hold: assert property (
      md1 == 3'h1 && waveform_line_o[1] && !timer_clr_i
      |=> waveform_line_o[1]) else $error("set");
   chk_period_reset: assert property (
      match_pulse_o[0] && !match_pulse_o[1] && $past(md1) == 3'h3
      |-> !waveform_line_o[1]) else $error("period");
   cover property (match_pulse_o[1]);
   cover property (match_pulse_o[0]);
   cover property ($rose(capture_overrun_o[1]));
endmodule // tcco_top_chk

bind tcco_top tcco_top_chk #(.NCH(NCH), .CW(CW)) u_chk (.clk_sys_i,
   .rst_b_i, .counter_i, .timer_clr_i, .measure_select_i, .overrun_clr_i,
   .waveform_mode_i, .direct_level_i, .channel_value_o, .channel_flag_o,
   .capture_overrun_o, .match_pulse_o, .waveform_line_o);

/* File: tcco_pin_model.sv */
// =================================================
// Far-side pins: two asynchronous capture sources per channel.
module tcco_pin_model #(
   parameter NCH = 2
) (
   input  wire            clk_sys_i,
   output logic [NCH-1:0] first_o,
   output logic [NCH-1:0] second_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      first_o = {NCH{1'b0}};
      second_o = {NCH{1'b0}};
   end
   // Pin edges land mid-cycle, a fixed 1.5 ns after the sampling edge.
   task automatic drive(input int w, input int c, input logic v);
      @(posedge clk_sys_i);
      #1.5;
      if (w == 0) first_o[c] = v;
      else second_o[c] = v;
   endtask
endmodule // tcco_pin_model

/* File: timer_capture_compare_output_tb.sv */
// =================================================
// Self-checking bench, channel 0 as period, channel 1 under test.
module timer_capture_compare_output_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WR = 0, RD = 2, FS = 4, FC = 6, OC = 8;
   logic        clk_sys_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic        tclr = 1'b0;
   logic [15:0] cnt = 16'h0000;
   logic [1:0]  ms = 2'h0, sy = 2'h0, dl = 2'h0;
   logic [3:0]  src = 4'h0, es = 4'h0;
   logic [5:0]  wm = 6'h00;
   logic [31:0] wd = 32'h00000000;
   logic [9:0]  pu = 10'h000;
   logic [1:0]  fi, se, fl, ov, il, si, mp, wl;
   logic [31:0] cv;
   int          n_fail = 0;
   int          checks_done = 0;
   always #2 clk_sys_i = ~clk_sys_i;
   tcco_pin_model #(.NCH(2)) u_pins (.clk_sys_i(clk_sys_i), .first_o(fi),
      .second_o(se));
   tcco_top #(.NCH(2)) dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
      .counter_i(cnt), .timer_clr_i(tclr), .measure_select_i(ms),
      .input_source_i(src), .edge_select_i(es), .sync_enable_i(sy),
      .first_input_i(fi), .second_input_i(se), .value_wr_i(pu[1:0]),
      .value_wdata_i(wd), .value_rd_i(pu[3:2]), .flag_set_i(pu[5:4]),
      .flag_clr_i(pu[7:6]), .overrun_clr_i(pu[9:8]), .waveform_mode_i(wm),
      .direct_level_i(dl), .channel_value_o(cv), .channel_flag_o(fl),
      .capture_overrun_o(ov), .input_level_o(il), .sampled_input_o(si),
      .match_pulse_o(mp), .waveform_line_o(wl));
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic pl(input int k);
      pu[k] = 1'b1;
      cyc(1);
      pu[k] = 1'b0;
   endtask
   task automatic run(input int n, input bit up);
      repeat (n) begin
         cnt = up ? cnt + 16'h0001 : cnt - 16'h0001;
         cyc(1);
      end
   endtask
   // Expected line after channel match and after period match.
   function automatic logic [1:0] ex(input int m, input logic d);
      case (m)
         1: ex = 2'b11;
         2: ex = {~d, 1'b0};
         3: ex = 2'b10;
         4: ex = {~d, ~d};
         5: ex = 2'b00;
         6: ex = {~d, 1'b1};
         default: ex = 2'b01;
      endcase
   endfunction
   task automatic t_swcap;
      ms[1] = 1'b1;
      src[3:2] = 2'h3;
      es[3:2] = 2'h3;
      cnt = 16'h1234;
      cyc(4);
      pl(RD + 1);
      pl(FC + 1);
      pl(OC + 1);
      chk(il[1], 1'b1);
      src[3:2] = 2'h2;
      cyc(2);
      chk({fl[1], ov[1]}, 2'h2);
      chk(cv[31:16], 16'h1234);
      cnt = 16'h2345;
      src[3:2] = 2'h3;
      cyc(2);
      chk(ov[1], 1'b1);
      chk(cv[31:16], 16'h2345);
      pl(OC + 1);
      chk(ov[1], 1'b0);
      sy[1] = 1'b1;
      pl(FC + 1);
      src[3:2] = 2'h2;
      cyc(1);
      chk(fl[1], 1'b0);
      cyc(1);
      chk({fl[1], il[1]}, 2'h2);
      $display("end t_swcap");
   endtask
   task automatic t_edges;
      sy[1] = 1'b0;
      for (int e = 0; e < 4; e++) begin
         es[3:2] = 2'h0;
         src[3:2] = 2'h2;
         cyc(2);
         pl(FC + 1);
         es[3:2] = e[1:0];
         src[3:2] = 2'h3;
         cyc(2);
         chk(fl[1], e[0]);
         pl(FC + 1);
         src[3:2] = 2'h2;
         cyc(2);
         chk(fl[1], e[1]);
      end
      $display("end t_edges");
   endtask
   task automatic t_pins;
      es[3:2] = 2'h0;
      src[3:2] = 2'h0;
      cnt = 16'h0ABC;
      cyc(2);
      pl(FC + 1);
      es[3:2] = 2'h1;
      u_pins.drive(0, 1, 1'b1);
      cyc(6);
      chk({fl[1], il[1]}, 2'h3);
      chk(cv[31:16], 16'h0ABC);
      es[3:2] = 2'h0;
      src[3:2] = 2'h1;
      cyc(2);
      pl(FC + 1);
      es[3:2] = 2'h1;
      u_pins.drive(0, 1, 1'b0);
      cyc(6);
      chk(fl[1], 1'b0);
      u_pins.drive(1, 1, 1'b1);
      cyc(6);
      chk(fl[1], 1'b1);
      $display("end t_pins");
   endtask
   task automatic t_wave;
      logic [1:0] x;
      ms = 2'h0;
      src[3:2] = 2'h3;
      wd = {16'h0008, 16'h0010};
      pl(WR);
      pl(WR + 1);
      pl(FC + 1);
      pl(FS + 1);
      chk(fl[1], 1'b1);
      for (int d = 0; d < 2; d++) begin
         for (int m = 1; m < 8; m++) begin
            x = ex(m, d[0]);
            cnt = 16'h0000;
            wm[5:3] = 3'h0;
            dl[1] = d[0];
            cyc(2);
            chk(wl[1], d[0]);
            pl(FC + 1);
            wm[5:3] = m[2:0];
            run(8, 1'b1);
            chk({mp, fl[1], si[1]}, 4'hB);
            chk(wl[1], x[1]);
            run(8, 1'b1);
            chk(mp, 2'h1);
            chk(wl[1], x[0]);
            if (m == 1) begin
               tclr = 1'b1;
               cyc(1);
               tclr = 1'b0;
               chk(wl[1], 1'b0);
            end
            run(8, 1'b0);
            chk(mp, 2'h2);
         end
      end
      $display("end t_wave");
   endtask
   task automatic print_verdict;
      $display("checks %0d, fails %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      cyc(8);
      rst_b_i = 1'b1;
      cyc(1);
      chk({fl, ov, il, si, mp, wl, cv[31:28]}, 16'h0000);
      t_swcap;
      t_edges;
      t_pins;
      t_wave;
      print_verdict;
   end
   initial begin
      #80000;
      n_fail++;
      print_verdict;
   end
endmodule // timer_capture_compare_output_tb
